// >>> hdl/fsec_top.sv
// Design decisions made here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
// How it works
// - secured: unsecured-code or debug flash/RAM access blocked
// - only code 1:0 means unsecured
// - reset copies nonvolatile option byte to working register
// - backdoor_allow zero disables key unlock
// - key_write_select set: key writes captured, not commands
// - clearing select with full match forces code 1:0
// - only secure-memory code may write key bytes
// - protection register written only by debug commands
// - successful blank check unsecures until reset
// - debug may still access unsecured resources
// - secure-memory code keeps full access always
// - divider bit 7 read-only; 6:0 write once
// - divisor_loaded set by first divider write
// - program/erase disabled until divisor_loaded
// - prescale_by_eight selects bus clock or bus/8
// - flash clock is input over divisor plus one
// - one timing pulse per flash clock period
// - seven 8-bit registers (two reserved), option/protect loaded at reset
// - security code sits in option bits 1:0
// - key range FFB0-FFB7 is key or command write
module fsec_top
#(
   parameter logic [15:0] RAM_LO   = 16'h0080,
   parameter logic [15:0] RAM_HI   = 16'h027F,
   parameter logic [15:0] FLASH_LO = 16'hE000,
   parameter logic [15:0] FLASH_HI = 16'hFFFF
)
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // axi4-lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // memory access from cpu or background debug
   input  wire logic        acc_req,
   input  wire logic        acc_wr,
   input  wire logic [15:0] acc_addr,
   input  wire logic [7:0]  acc_wdata,
   input  wire logic        acc_src_secure,
   input  wire logic        acc_from_debug,
   input  wire logic [7:0]  mem_rdata,
   output logic             acc_ack,
   output logic             acc_blocked,
   output logic [7:0]       acc_rdata,
   output logic             mem_we,
   output logic [15:0]      mem_waddr,
   output logic [7:0]       mem_wdata,
   // background debug write to protection register
   input  wire logic        dbg_prot_we,
   input  wire logic [7:0]  dbg_prot_wdata,
   // nonvolatile storage side
   input  wire logic [7:0]  nv_option_byte,
   input  wire logic [7:0]  nv_protect_byte,
   input  wire logic [63:0] backdoor_key_store,
   input  wire logic        blank_check_erased,
   // flash engine side
   output logic             flash_pe_enable,
   output logic             fclk_tick,
   output logic             secured,
   output logic [7:0]       protect_working_reg
);

   typedef struct packed
   {
      logic        aw_got;
      logic [7:0]  aw_addr;
      logic        w_got;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        aw_rdy;
      logic        w_rdy;
      logic        ar_rdy;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
      logic        nv_loaded;
      logic [7:0]  opt;
      logic [7:0]  prot;
      logic        kws;
      logic        divisor_loaded;
      logic [6:0]  div;
      logic        unlocked;
      logic        secured;
      logic        ack;
      logic        blocked;
      logic [7:0]  rd;
      logic        mwe;
      logic [15:0] maddr;
      logic [7:0]  mdata;
      logic        key_we;
      logic [2:0]  key_idx;
      logic [7:0]  key_data;
      logic        key_clear;
   } fsec_top_st_t;

   fsec_top_st_t st_ff;
   fsec_top_st_t nxt_st;
   logic         key_match;
   logic         fclk_in_range;

   // ------------------------------------------------------------
   // reset constants
   // ------------------------------------------------------------
   localparam fsec_top_st_t ST_RST = '{
      opt     : fsec_pkg::OPTION_RST,
      prot    : fsec_pkg::PROTECT_RST,
      div     : fsec_pkg::DIV_RST,
      secured : 1'b1,
      default : '0
   };

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      logic        in_secure;
      logic        is_key;
      logic        allow;
      logic        wr_fire;
      logic [31:0] rword;
      logic        rok;
      in_secure = 1'b0;
      is_key    = 1'b0;
      allow     = 1'b0;
      wr_fire   = 1'b0;
      rword     = 32'h0000_0000;
      rok       = 1'b1;
      nxt_st    = st_ff;

      // nonvolatile bytes are caught on the first edge after release
      if (!st_ff.nv_loaded)
      begin
         nxt_st.nv_loaded = 1'b1;
         nxt_st.opt       = nv_option_byte;
         nxt_st.prot      = nv_protect_byte;
      end

      if (dbg_prot_we)
      begin
         nxt_st.prot = dbg_prot_wdata;
      end

      // ----------------------------------------------------------
      // axi write channel, address and data in either order
      // ----------------------------------------------------------
      if (s_axi_awvalid && st_ff.aw_rdy)
      begin
         nxt_st.aw_got  = 1'b1;
         nxt_st.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_ff.w_rdy)
      begin
         nxt_st.w_got = 1'b1;
         nxt_st.wdata = s_axi_wdata;
         nxt_st.wstrb = s_axi_wstrb;
      end
      if (st_ff.bvalid && s_axi_bready)
      begin
         nxt_st.bvalid = 1'b0;
      end
      if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid)
      begin
         wr_fire       = 1'b1;
         nxt_st.aw_got = 1'b0;
         nxt_st.w_got  = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp  = fsec_pkg::RESP_OKAY;
      end
      nxt_st.key_clear = 1'b0;
      if (wr_fire && st_ff.wstrb[0])
      begin
         case (st_ff.aw_addr)
            fsec_pkg::OFS_CLK_DIV:
            begin
               if (!st_ff.divisor_loaded)
               begin
                  nxt_st.divisor_loaded = 1'b1;
                  nxt_st.div   = st_ff.wdata[fsec_pkg::PRESCALE_BIT:0];
               end
            end
            fsec_pkg::OFS_CONFIG:
            begin
               nxt_st.kws = st_ff.wdata[fsec_pkg::KWS_BIT];
               if (st_ff.wdata[fsec_pkg::KWS_BIT] && !st_ff.kws)
               begin
                  nxt_st.key_clear = 1'b1;
               end
               // only a full match with the backdoor open unlocks
               if (!st_ff.wdata[fsec_pkg::KWS_BIT] && st_ff.kws && key_match &&
                   st_ff.opt[fsec_pkg::BACKDOOR_BIT])
               begin
                  nxt_st.unlocked = 1'b1;
               end
            end
            fsec_pkg::OFS_OPTION, fsec_pkg::OFS_PROTECT, fsec_pkg::OFS_RSV0,
            fsec_pkg::OFS_RSV1, fsec_pkg::OFS_SEC_STAT:
            begin
               // application writes to the protection copy are dropped
               nxt_st.bresp = fsec_pkg::RESP_OKAY;
            end
            default:
            begin
               nxt_st.bresp = fsec_pkg::RESP_SLVERR;
            end
         endcase
      end
      else if (wr_fire)
      begin
         case (st_ff.aw_addr)
            fsec_pkg::OFS_CLK_DIV, fsec_pkg::OFS_OPTION, fsec_pkg::OFS_CONFIG, fsec_pkg::OFS_PROTECT,
            fsec_pkg::OFS_RSV0, fsec_pkg::OFS_RSV1, fsec_pkg::OFS_SEC_STAT:
            begin
               nxt_st.bresp = fsec_pkg::RESP_OKAY;
            end
            default:
            begin
               nxt_st.bresp = fsec_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (blank_check_erased)
      begin
         nxt_st.unlocked = 1'b1;
      end
      if (nxt_st.unlocked && st_ff.nv_loaded)
      begin
         nxt_st.opt[1:0] = fsec_pkg::SEC_UNSECURED;
      end
      nxt_st.aw_rdy = !nxt_st.aw_got && !nxt_st.bvalid;
      nxt_st.w_rdy  = !nxt_st.w_got && !nxt_st.bvalid;

      // ----------------------------------------------------------
      // axi read channel
      // ----------------------------------------------------------
      case (s_axi_araddr)
         fsec_pkg::OFS_CLK_DIV:  rword = {24'h0, st_ff.divisor_loaded, st_ff.div};
         fsec_pkg::OFS_OPTION:   rword = {24'h0, st_ff.opt};
         fsec_pkg::OFS_CONFIG:   rword = {24'h0, 2'h0, st_ff.kws, 5'h00};
         fsec_pkg::OFS_PROTECT:  rword = {24'h0, st_ff.prot};
         fsec_pkg::OFS_RSV0:     rword = 32'h0000_0000;
         fsec_pkg::OFS_RSV1:     rword = 32'h0000_0000;
         fsec_pkg::OFS_SEC_STAT: rword = {28'h0, st_ff.unlocked, fclk_in_range, st_ff.divisor_loaded, st_ff.secured};
         default:
         begin
            rword = 32'h0000_0000;
            rok   = 1'b0;
         end
      endcase
      if (st_ff.rvalid && s_axi_rready)
      begin
         nxt_st.rvalid = 1'b0;
      end
      if (s_axi_arvalid && st_ff.ar_rdy)
      begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rdata  = rword;
         nxt_st.rresp  = rok ? fsec_pkg::RESP_OKAY : fsec_pkg::RESP_SLVERR;
      end
      nxt_st.ar_rdy = !nxt_st.rvalid && !(s_axi_arvalid && st_ff.ar_rdy);

      // ----------------------------------------------------------
      // security state and memory access gate
      // ----------------------------------------------------------
      nxt_st.secured = !st_ff.nv_loaded || (nxt_st.opt[1:0] != fsec_pkg::SEC_UNSECURED);
      in_secure = (acc_addr >= RAM_LO && acc_addr <= RAM_HI) ||
                  (acc_addr >= FLASH_LO && acc_addr <= FLASH_HI);
      allow     = !st_ff.secured || !in_secure ||
                  (acc_src_secure && !acc_from_debug);
      is_key    = acc_addr >= fsec_pkg::KEY_ADDR_LO && acc_addr <= fsec_pkg::KEY_ADDR_HI;
      nxt_st.ack      = acc_req;
      nxt_st.blocked  = acc_req && !allow;
      nxt_st.rd       = (acc_req && !acc_wr && allow) ? mem_rdata : 8'h00;
      nxt_st.mwe      = 1'b0;
      nxt_st.key_we   = 1'b0;
      nxt_st.maddr    = acc_addr;
      nxt_st.mdata    = acc_wdata;
      nxt_st.key_idx  = acc_addr[2:0];
      nxt_st.key_data = acc_wdata;
      if (acc_req && acc_wr && allow)
      begin
         if (is_key && st_ff.kws)
         begin
            nxt_st.key_we = acc_src_secure && !acc_from_debug && st_ff.opt[fsec_pkg::BACKDOOR_BIT];
         end
         else
         begin
            nxt_st.mwe = 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_ff <= ST_RST;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   // ------------------------------------------------------------
   // children
   // ------------------------------------------------------------
   fsec_key_cmp u_key
   (
      .clk                (clk),
      .rst_b              (rst_b),
      .clear              (st_ff.key_clear),
      .we                 (st_ff.key_we),
      .idx                (st_ff.key_idx),
      .data               (st_ff.key_data),
      .backdoor_key_store (backdoor_key_store),
      .match              (key_match)
   );

   fsec_clk_div u_div
   (
      .clk               (clk),
      .rst_b             (rst_b),
      .enable            (st_ff.divisor_loaded),
      .prescale_by_eight (st_ff.div[fsec_pkg::PRESCALE_BIT]),
      .divisor           (st_ff.div[fsec_pkg::DIV_MSB:0]),
      .fclk_tick         (fclk_tick),
      .fclk_in_range     (fclk_in_range)
   );

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign s_axi_awready       = st_ff.aw_rdy;
   assign s_axi_wready        = st_ff.w_rdy;
   assign s_axi_bvalid        = st_ff.bvalid;
   assign s_axi_bresp         = st_ff.bresp;
   assign s_axi_arready       = st_ff.ar_rdy;
   assign s_axi_rvalid        = st_ff.rvalid;
   assign s_axi_rresp         = st_ff.rresp;
   assign s_axi_rdata         = st_ff.rdata;
   assign acc_ack             = st_ff.ack;
   assign acc_blocked         = st_ff.blocked;
   assign acc_rdata           = st_ff.rd;
   assign mem_we              = st_ff.mwe;
   assign mem_waddr           = st_ff.maddr;
   assign mem_wdata           = st_ff.mdata;
   assign flash_pe_enable     = st_ff.divisor_loaded;
   assign secured             = st_ff.secured;
   assign protect_working_reg = st_ff.prot;

endmodule

// >>> hdl/fsec_pkg.sv
package fsec_pkg;

   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_CLK_DIV  = 8'h00;
   localparam logic [7:0] OFS_OPTION   = 8'h04;
   localparam logic [7:0] OFS_CONFIG   = 8'h08;
   localparam logic [7:0] OFS_PROTECT  = 8'h0C;
   localparam logic [7:0] OFS_RSV0     = 8'h10;
   localparam logic [7:0] OFS_RSV1     = 8'h14;
   localparam logic [7:0] OFS_SEC_STAT = 8'h18;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int DIVISOR_LOADED_BIT      = 7;
   localparam int PRESCALE_BIT   = 6;
   localparam int DIV_MSB        = 5;
   localparam int BACKDOOR_BIT   = 7;
   localparam int KWS_BIT        = 5;
   localparam int ST_SECURED_BIT = 0;
   localparam int ST_DIVISOR_LOADED_BIT   = 1;
   localparam int ST_RANGE_BIT   = 2;
   localparam int ST_UNLOCK_BIT  = 3;

   // ------------------------------------------------------------
   // codes and reset values
   // ------------------------------------------------------------
   localparam logic [1:0] SEC_UNSECURED  = 2'h2;
   localparam logic [7:0] OPTION_RST     = 8'hFF;
   localparam logic [7:0] PROTECT_RST    = 8'hFF;
   localparam logic [6:0] DIV_RST        = 7'h00;
   localparam logic [15:0] KEY_ADDR_LO   = 16'hFFB0;
   localparam logic [15:0] KEY_ADDR_HI   = 16'hFFB7;
   localparam logic [1:0] RESP_OKAY      = 2'h0;
   localparam logic [1:0] RESP_SLVERR    = 2'h2;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int BUS_CLK_HZ   = 50_000_000;
   localparam int FCLK_MAX_HZ  = 200_000;
   localparam int FCLK_MIN_HZ  = 150_000;
   localparam int PRESCALE_DIV = 8;
   // shortest allowed period rounds up, longest rounds down
   localparam logic [9:0] FCLK_MIN_CYC = 10'((BUS_CLK_HZ + FCLK_MAX_HZ - 1) / FCLK_MAX_HZ);
   localparam logic [9:0] FCLK_MAX_CYC = 10'(BUS_CLK_HZ / FCLK_MIN_HZ);

endpackage

// >>> hdl/fsec_clk_div.sv
`timescale 1ns/1ps
module fsec_clk_div
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_b,
   // divider setting
   input  wire logic       enable,
   input  wire logic       prescale_by_eight,
   input  wire logic [5:0] divisor,
   // flash clock
   output logic            fclk_tick,
   output logic            fclk_in_range
);

   typedef struct packed
   {
      logic [2:0] pre;
      logic [5:0] cnt;
      logic       tick;
      logic       in_range;
   } fsec_div_st_t;

   fsec_div_st_t st_ff;
   fsec_div_st_t nxt_st;
   logic [9:0]   period;

   always_comb
   begin
      nxt_st = st_ff;
      period = prescale_by_eight ? {1'b0, divisor + 6'h0, 3'h0} + 10'h008 : {4'h0, divisor} + 10'h001;
      nxt_st.in_range = enable && period >= fsec_pkg::FCLK_MIN_CYC && period <= fsec_pkg::FCLK_MAX_CYC;
      nxt_st.tick = 1'b0;
      if (!enable)
      begin
         nxt_st.pre = 3'h0;
         nxt_st.cnt = 6'h00;
      end
      else if (!prescale_by_eight || st_ff.pre == 3'h7)
      begin
         nxt_st.pre = 3'h0;
         if (st_ff.cnt >= divisor)
         begin
            nxt_st.cnt  = 6'h00;
            nxt_st.tick = 1'b1;
         end
         else
         begin
            nxt_st.cnt = st_ff.cnt + 6'h01;
         end
      end
      else
      begin
         nxt_st.pre = st_ff.pre + 3'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_ff <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign fclk_tick     = st_ff.tick;
   assign fclk_in_range = st_ff.in_range;

endmodule

// >>> hdl/fsec_key_cmp.sv
`timescale 1ns/1ps
module fsec_key_cmp
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // capture port
   input  wire logic        clear,
   input  wire logic        we,
   input  wire logic [2:0]  idx,
   input  wire logic [7:0]  data,
   // stored key, byte 0 at bits 7:0
   input  wire logic [63:0] backdoor_key_store,
   // result
   output logic             match
);

   typedef struct packed
   {
      logic [63:0] bytes;
      logic [7:0]  seen;
      logic        match;
   } fsec_key_st_t;

   fsec_key_st_t st_ff;
   fsec_key_st_t nxt_st;

   always_comb
   begin
      nxt_st = st_ff;
      if (clear)
      begin
         nxt_st.seen = 8'h00;
      end
      else if (we)
      begin
         // any write order works; each write lands by its own address
         nxt_st.bytes[{idx, 3'h0} +: 8] = data;
         nxt_st.seen[idx] = 1'b1;
      end
      nxt_st.match = (st_ff.seen == 8'hFF) && (st_ff.bytes == backdoor_key_store);
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_ff <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign match = st_ff.match;

endmodule

// >>> testbench/fsec_properties.sv
`timescale 1ns/1ps
module fsec_properties
#(
   parameter logic [15:0] RAM_LO   = 16'h0080,
   parameter logic [15:0] RAM_HI   = 16'h027F,
   parameter logic [15:0] FLASH_LO = 16'hE000,
   parameter logic [15:0] FLASH_HI = 16'hFFFF
)
(
   // clock and reset
   input wire logic        clk,
   input wire logic        rst_b,
   // access port
   input wire logic        acc_req,
   input wire logic        acc_wr,
   input wire logic [15:0] acc_addr,
   input wire logic [7:0]  acc_wdata,
   input wire logic        acc_src_secure,
   input wire logic        acc_from_debug,
   input wire logic [7:0]  mem_rdata,
   input wire logic        acc_ack,
   input wire logic        acc_blocked,
   input wire logic [7:0]  acc_rdata,
   input wire logic        mem_we,
   input wire logic [15:0] mem_waddr,
   input wire logic [7:0]  mem_wdata,
   // debug, storage and state
   input wire logic        dbg_prot_we,
   input wire logic [7:0]  dbg_prot_wdata,
   input wire logic        blank_check_erased,
   input wire logic        flash_pe_enable,
   input wire logic        secured,
   input wire logic [7:0]  protect_working_reg
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   logic in_mem;
   logic in_key;
   assign in_mem = (acc_addr >= RAM_LO && acc_addr <= RAM_HI) || (acc_addr >= FLASH_LO && acc_addr <= FLASH_HI);
   assign in_key = acc_addr >= fsec_pkg::KEY_ADDR_LO && acc_addr <= fsec_pkg::KEY_ADDR_HI;
   sequence s_open_req;
      acc_req && acc_src_secure && !acc_from_debug && !in_key;
   endsequence
   sequence s_bad_req;
      acc_req && secured && in_mem && (acc_from_debug || !acc_src_secure);
   endsequence
   a_block_sec_mem: assert property (s_bad_req |=> acc_blocked && acc_rdata == 8'h00 && !mem_we)
      else $error("blocked access leaked");
   a_secure_wr_fwd: assert property (s_open_req ##0 acc_wr |=> mem_we && mem_waddr == $past(acc_addr)
      && mem_wdata == $past(acc_wdata)) else $error("secure write not forwarded");
   a_secure_rd_pass: assert property (s_open_req ##0 !acc_wr |=> !acc_blocked && acc_rdata == $past(mem_rdata))
      else $error("secure read altered");
   a_unsec_res_open: assert property (acc_req && !in_mem |=> acc_ack && !acc_blocked)
      else $error("unsecured resource blocked");
   a_blank_unsec: assert property (blank_check_erased |=> !secured)
      else $error("blank check kept security");
   a_unlock_holds: assert property (!secured |=> !secured)
      else $error("security came back");
   a_div_loaded_hold: assert property (flash_pe_enable |=> flash_pe_enable)
      else $error("divisor flag dropped");
   a_prot_dbg_wr: assert property (dbg_prot_we |=> protect_working_reg == $past(dbg_prot_wdata))
      else $error("debug protect write lost");
endmodule
bind fsec_top fsec_properties #(.RAM_LO(RAM_LO), .RAM_HI(RAM_HI), .FLASH_LO(FLASH_LO), .FLASH_HI(FLASH_HI))
   fsec_properties_i (.*);

// >>> testbench/fsec_cpu_model.sv
`timescale 1ns/1ps
module fsec_cpu_model
(
   // clock
   input  wire logic        clk,
   // request side
   output logic             acc_req,
   output logic             acc_wr,
   output logic [15:0]      acc_addr,
   output logic [7:0]       acc_wdata,
   output logic             acc_src_secure,
   output logic             acc_from_debug,
   output logic [7:0]       mem_rdata,
   // answer side
   input  wire logic        acc_ack,
   input  wire logic        acc_blocked,
   input  wire logic [7:0]  acc_rdata,
   input  wire logic        mem_we
);
   // memory content is a fixed function of address so reads are predictable
   assign mem_rdata = acc_addr[7:0] ^ 8'hA5;
   initial
   begin
      acc_req = 1'b0;
      acc_wr = 1'b0;
      acc_addr = 16'h0000;
      acc_wdata = 8'h00;
      acc_src_secure = 1'b0;
      acc_from_debug = 1'b0;
   end
   // one request, then an idle edge, so key bytes never land on adjacent cycles
   task automatic access(input logic w, input logic [15:0] a, input logic [7:0] d, input logic s, input logic g,
                         output logic [7:0] rd, output logic bl, output logic we);
      @(posedge clk);
      acc_req <= 1'b1;
      acc_wr <= w;
      acc_addr <= a;
      acc_wdata <= d;
      acc_src_secure <= s;
      acc_from_debug <= g;
      @(posedge clk);
      acc_req <= 1'b0;
      acc_addr <= ~a;
      acc_wdata <= ~d;
      @(posedge clk);
      rd = acc_rdata;
      bl = acc_blocked;
      we = mem_we;
   endtask
endmodule

// >>> testbench/fsec_tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; $display("Error %s expected %h seen %h", n, e, g); end end
module fsec_tb_top;
   localparam logic [63:0] KEY = 64'h0123456789ABCDEF;
   logic clk, rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, acc_req, acc_wr, acc_src_secure;
   logic acc_from_debug, acc_ack, acc_blocked, mem_we, dbg_prot_we, blank_check_erased, flash_pe_enable;
   logic fclk_tick, secured;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, acc_wdata, mem_rdata, acc_rdata, mem_wdata, dbg_prot_wdata;
   logic [7:0]  nv_option_byte, nv_protect_byte, protect_working_reg, rd8;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [15:0] acc_addr, mem_waddr;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
   logic [63:0] backdoor_key_store;
   logic        bl, we;
   int          n_fail, tests_run, n, i;
   logic [7:0]  opts [4] = '{8'h03, 8'h80, 8'h82, 8'h81};
   logic [7:0]  divs [4] = '{8'h03, 8'hC6, 8'h5F, 8'h09};
   fsec_top fsec_top_i (.*);
   fsec_cpu_model fsec_cpu_model_i (.*);
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever
      begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid)
         begin
            s_axi_bready <= 1'b0;
            break;
         end
      end
   endtask
   task automatic axi_rd(input logic [7:0] a);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever
      begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid)
         begin
            rd = s_axi_rdata;
            rs = s_axi_rresp;
            s_axi_rready <= 1'b0;
            break;
         end
      end
   endtask
   task automatic do_reset(input logic [7:0] opt);
      rst_b <= 1'b0;
      nv_option_byte <= opt;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk);
   endtask
   // debug entry sets no secure source; a bad key flips bit 0 of the last byte
   task automatic key_seq(input logic g, input logic bad);
      axi_wr(8'h08, 32'h20);
      for (int j = 0; j < 8; j++)
      begin
         fsec_cpu_model_i.access(1'b1, 16'hFFB0 + 16'(j), KEY[j*8 +: 8] ^ {7'h00, bad && j == 7}, !g, g, rd8, bl, we);
         `CHK("key_fwd", 1'b0, we)
      end
      repeat (2) @(posedge clk);
      axi_wr(8'h08, 32'h00);
      repeat (3) @(posedge clk);
   endtask
   initial
   begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hF;
      {dbg_prot_we, dbg_prot_wdata, blank_check_erased} = 10'h000;
      nv_protect_byte = 8'h5A;
      backdoor_key_store = KEY;
      for (i = 0; i < 4; i++)
      begin
         do_reset(opts[i]);
         axi_rd(8'h18);
         `CHK("secured", opts[i][1:0] !== 2'h2, rd[0])
         axi_rd(8'h04);
         `CHK("option", {24'h0, opts[i]}, rd)
         axi_rd(8'h00);
         `CHK("div_reset", 32'h0, rd)
         `CHK("pe_off", 1'b0, flash_pe_enable)
         axi_wr(8'h00, {24'h0, divs[i]});
         axi_wr(8'h00, 32'h7F);
         axi_rd(8'h00);
         `CHK("div", {24'h0, 8'h80 | divs[i]}, rd)
         `CHK("pe_on", 1'b1, flash_pe_enable)
         @(posedge clk iff fclk_tick);
         n = 0;
         do begin @(posedge clk); n++; end while (fclk_tick !== 1'b1 && n < 600);
         `CHK("period", (divs[i][6] ? 8 : 1) * (divs[i][5:0] + 1), n)
         axi_rd(8'h18);
         `CHK("in_range", i == 2, rd[2])
         if (i == 0) key_seq(1'b0, 1'b0);
         if (i == 0) `CHK("no_backdoor", 1'b1, secured)
      end
      axi_rd(8'h0C);
      `CHK("protect", 32'h5A, rd)
      axi_wr(8'h0C, 32'h00);
      axi_rd(8'h0C);
      `CHK("protect_sw", 32'h5A, rd)
      @(posedge clk);
      dbg_prot_we <= 1'b1;
      dbg_prot_wdata <= 8'h33;
      @(posedge clk);
      dbg_prot_we <= 1'b0;
      @(posedge clk);
      `CHK("protect_dbg", 8'h33, protect_working_reg)
      axi_rd(8'h1C);
      `CHK("unmapped", fsec_pkg::RESP_SLVERR, rs)
      fsec_cpu_model_i.access(1'b0, 16'h0100, 8'h00, 1'b0, 1'b0, rd8, bl, we);
      `CHK("ram_rd_blk", 9'h100, {bl, rd8})
      fsec_cpu_model_i.access(1'b1, 16'hE100, 8'h55, 1'b1, 1'b1, rd8, bl, we);
      `CHK("dbg_wr_blk", 2'h2, {bl, we})
      fsec_cpu_model_i.access(1'b0, 16'h0010, 8'h00, 1'b0, 1'b1, rd8, bl, we);
      `CHK("dbg_page", 9'h0B5, {bl, rd8})
      fsec_cpu_model_i.access(1'b0, 16'h0100, 8'h00, 1'b1, 1'b0, rd8, bl, we);
      `CHK("secure_rd", 9'h0A5, {bl, rd8})
      fsec_cpu_model_i.access(1'b1, 16'h0100, 8'h3C, 1'b1, 1'b0, rd8, bl, we);
      key_seq(1'b1, 1'b0);
      `CHK("dbg_key", 1'b1, secured)
      key_seq(1'b0, 1'b1);
      `CHK("bad_key", 1'b1, secured)
      key_seq(1'b0, 1'b0);
      `CHK("good_key", 1'b0, secured)
      axi_rd(8'h04);
      `CHK("code", 2'h2, rd[1:0])
      fsec_cpu_model_i.access(1'b0, 16'h0100, 8'h00, 1'b0, 1'b1, rd8, bl, we);
      `CHK("open_ram", 9'h0A5, {bl, rd8})
      do_reset(8'h81);
      blank_check_erased <= 1'b1;
      @(posedge clk);
      blank_check_erased <= 1'b0;
      @(posedge clk);
      `CHK("blank", 1'b0, secured)
      end_sim();
   end
   initial
   begin
      #2_000_000;
      n_fail++;
      end_sim();
   end
endmodule
